/* File: pkg/ufc_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef UFC_REGS_SVH
`define UFC_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define UFC_OFS_FRAME_CTRL 4'h0
`define UFC_OFS_STATUS 4'h1
`define UFC_OFS_DATA 4'h2
`define UFC_OFS_IRQ_STS 4'h3
`define UFC_OFS_IRQ_EN 4'h4
`define UFC_OFS_IRQ_CLR 4'h5
`define UFC_OFS_MUTE 4'h6

// ****************************************
// Frame control fields
// ****************************************
`define UFC_FC_RX_NINTH 7
`define UFC_FC_TX_NINTH 6
`define UFC_FC_DISABLE 5
`define UFC_FC_WORD_LEN 4
`define UFC_FC_WAKE 3
`define UFC_FC_PCE 2
`define UFC_FC_PTYPE 1
`define UFC_FC_PIE 0

// ****************************************
// Status and interrupt fields
// ****************************************
`define UFC_ST_PERR 0
`define UFC_ST_RX_READY 1
`define UFC_ST_TX_PEND 2
`define UFC_ST_TX_BUSY 3
`define UFC_IRQ_PERR 0
`define UFC_IRQ_RX_DONE 1
`define UFC_IRQ_TX_DONE 2

// ****************************************
// Reset values
// ****************************************
`define UFC_RST_FRAME_CTRL 8'h00
`define UFC_RST_IRQ_EN 3'h0

// ****************************************
// Timing counts
// ****************************************
`define UFC_OVS 16
`define UFC_MID 8
`define UFC_BITS_FRAME8 10
`define UFC_BITS_FRAME9 11

`endif

/* File: pkg/ufc_pkg.sv */
// Types shared by the frame format control block
package ufc_pkg;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ufc_bus_req_t;

    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ufc_tx_st_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ufc_rx_st_t;

    typedef struct packed {
        logic [15:0] presc;
        ufc_tx_st_t tx_st;
        logic [3:0] tx_sub;
        logic [3:0] tx_bit;
        logic [8:0] tx_sh;
        logic tx_len9;
        logic tx_line;
        logic [7:0] tx_hold;
        logic tx_pend;
        ufc_rx_st_t rx_st;
        logic [3:0] rx_sub;
        logic [3:0] rx_bit;
        logic [8:0] rx_sh;
        logic rx_len9;
        logic rx_pce;
        logic rx_ps;
        logic [7:0] rx_data;
        logic rx_ready;
        logic [7:0] idle_cnt;
        logic [7:0] ctrl;
        logic pe_flag;
        logic pe_armed;
        logic mute;
        logic [2:0] irq_sts;
        logic [2:0] irq_en;
        logic [7:0] rdata;
    } ufc_state_t;

endpackage : ufc_pkg

/* File: src/ufc_frame_ctrl.sv */
// Serial frame format and parity control with a small transmit and receive engine
`timescale 1ns/1ps
`default_nettype none
`include "ufc_regs.svh"
// What this block does
// [RULE_01] Reset clears every frame control bit; the received ninth bit has no defined value.
// [RULE_02] In nine-bit mode the received ninth bit is stored in control bit 7.
// [RULE_03] In nine-bit mode control bit 6 is sent as the ninth bit.
// [RULE_04] Disable bit stops prescaler and outputs and aborts the transfer in progress.
// [RULE_05] Word length bit selects eight or nine data bits, one start, one stop.
// [RULE_06] Software must not change word length during a transfer.
// [RULE_07] Wake bit picks mute exit by idle line (0) or address mark (1).
// [RULE_08] With parity on, transmitter puts parity in the top data position.
// [RULE_09] With parity on, receiver checks each word against the chosen parity type.
// [RULE_10] Parity enable changes apply only after the current byte, both directions.
// [RULE_11] Parity select bit 1 chooses even (0) or odd (1) parity.
// [RULE_12] Parity type changes apply only after the byte in progress.
// [RULE_13] Parity interrupt enable bit 0 gates the parity error request.
// [RULE_14] Receiver sets parity error flag; status read then data access clears it.

module ufc_frame_ctrl
    import ufc_pkg::*;
#(
    parameter int SAMPLE_DIV = 13
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic CE,
    // Register port
    input wire ufc_bus_req_t BUS_REQ,
    output logic [7:0] RDATA,
    // Serial line
    input wire logic RXD,
    output logic TXD,
    output logic TXD_OE,
    // Interrupt
    output logic IRQ
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [3:0] last_bit(input logic len9);
        last_bit = len9 ? 4'h8 : 4'h7;
    endfunction : last_bit

    // Parity bit over the data bits below the top position
    function automatic logic calc_par(input logic [8:0] w, input logic len9, input logic odd);
        calc_par = (len9 ? ^w[7:0] : ^w[6:0]) ^ odd;
    endfunction : calc_par

    ufc_state_t s_ff;
    ufc_state_t nxt_s;
    logic tick;
    logic dis;
    logic [8:0] word;
    logic word_top;
    logic perr;
    logic accept;
    logic [7:0] idle_limit;
    logic [15:0] presc_last;

    assign dis = s_ff.ctrl[`UFC_FC_DISABLE];
    assign presc_last = 16'(SAMPLE_DIV - 1);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        nxt_s = s_ff;
        tick = 1'b0;
        word = 9'h000;
        word_top = 1'b0;
        perr = 1'b0;
        accept = 1'b0;
        idle_limit = 8'h00;
        if (CE) begin
            // Bus side effects first so hardware sets below win
            if (BUS_REQ.rd) begin
                case (BUS_REQ.addr)
                    `UFC_OFS_FRAME_CTRL: nxt_s.rdata = s_ff.ctrl;
                    `UFC_OFS_STATUS: begin
                        nxt_s.rdata = {4'h0, s_ff.tx_st != TX_IDLE, s_ff.tx_pend,
                                       s_ff.rx_ready, s_ff.pe_flag};
                        nxt_s.pe_armed = s_ff.pe_flag; // [RULE_14]
                    end
                    `UFC_OFS_DATA: begin
                        nxt_s.rdata = s_ff.rx_data;
                        nxt_s.rx_ready = 1'b0;
                        nxt_s.pe_armed = 1'b0;
                        if (s_ff.pe_armed) begin
                            nxt_s.pe_flag = 1'b0; // [RULE_14]
                        end
                    end
                    `UFC_OFS_IRQ_STS: nxt_s.rdata = {5'h00, s_ff.irq_sts};
                    `UFC_OFS_IRQ_EN: nxt_s.rdata = {5'h00, s_ff.irq_en};
                    `UFC_OFS_MUTE: nxt_s.rdata = {7'h00, s_ff.mute};
                    default: nxt_s.rdata = 8'h00;
                endcase
            end
            if (BUS_REQ.wr) begin
                case (BUS_REQ.addr)
                    `UFC_OFS_FRAME_CTRL: nxt_s.ctrl = BUS_REQ.wdata;
                    `UFC_OFS_DATA: begin
                        nxt_s.tx_hold = BUS_REQ.wdata;
                        nxt_s.tx_pend = 1'b1;
                        nxt_s.pe_armed = 1'b0;
                        if (s_ff.pe_armed) begin
                            nxt_s.pe_flag = 1'b0; // [RULE_14]
                        end
                    end
                    `UFC_OFS_IRQ_EN: nxt_s.irq_en = BUS_REQ.wdata[2:0];
                    `UFC_OFS_IRQ_CLR: nxt_s.irq_sts = s_ff.irq_sts & ~BUS_REQ.wdata[2:0];
                    `UFC_OFS_MUTE: nxt_s.mute = BUS_REQ.wdata[0];
                    default: ;
                endcase
            end

            // Prescaler, held at zero while disabled
            if (dis) begin
                nxt_s.presc = 16'h0000; // [RULE_04]
            end else if (s_ff.presc == presc_last) begin
                nxt_s.presc = 16'h0000;
                tick = 1'b1;
            end else begin
                nxt_s.presc = s_ff.presc + 16'h0001;
            end

            // ****************************************
            // Transmitter
            // ****************************************
            case (s_ff.tx_st)
                TX_IDLE: begin
                    nxt_s.tx_line = 1'b1;
                    // Start on a tick so the start bit lasts a full bit time
                    if (s_ff.tx_pend && !dis && tick) begin
                        // Format sampled only at frame start
                        nxt_s.tx_len9 = s_ff.ctrl[`UFC_FC_WORD_LEN]; // [RULE_05]
                        nxt_s.tx_sh = {s_ff.ctrl[`UFC_FC_TX_NINTH], s_ff.tx_hold}; // [RULE_03]
                        if (s_ff.ctrl[`UFC_FC_PCE]) begin // [RULE_10] [RULE_12]
                            if (s_ff.ctrl[`UFC_FC_WORD_LEN]) begin
                                nxt_s.tx_sh[8] = calc_par(nxt_s.tx_sh, 1'b1,
                                    s_ff.ctrl[`UFC_FC_PTYPE]); // [RULE_08] [RULE_11]
                            end else begin
                                nxt_s.tx_sh[7] = calc_par(nxt_s.tx_sh, 1'b0,
                                    s_ff.ctrl[`UFC_FC_PTYPE]); // [RULE_08] [RULE_11]
                            end
                        end
                        // A byte written in the cycle the held one is taken stays pending
                        nxt_s.tx_pend = BUS_REQ.wr && BUS_REQ.addr == `UFC_OFS_DATA;
                        nxt_s.tx_sub = 4'h0;
                        nxt_s.tx_line = 1'b0;
                        nxt_s.tx_st = TX_START;
                    end
                end
                TX_START: begin
                    if (tick) begin
                        if (s_ff.tx_sub == 4'(`UFC_OVS - 1)) begin
                            nxt_s.tx_sub = 4'h0;
                            nxt_s.tx_bit = 4'h0;
                            nxt_s.tx_line = s_ff.tx_sh[0];
                            nxt_s.tx_st = TX_DATA;
                        end else begin
                            nxt_s.tx_sub = s_ff.tx_sub + 4'h1;
                        end
                    end
                end
                TX_DATA: begin
                    if (tick) begin
                        if (s_ff.tx_sub == 4'(`UFC_OVS - 1)) begin
                            nxt_s.tx_sub = 4'h0;
                            if (s_ff.tx_bit == last_bit(s_ff.tx_len9)) begin // [RULE_05]
                                nxt_s.tx_line = 1'b1;
                                nxt_s.tx_st = TX_STOP;
                            end else begin
                                nxt_s.tx_bit = s_ff.tx_bit + 4'h1;
                                nxt_s.tx_sh = {1'b0, s_ff.tx_sh[8:1]};
                                nxt_s.tx_line = s_ff.tx_sh[1];
                            end
                        end else begin
                            nxt_s.tx_sub = s_ff.tx_sub + 4'h1;
                        end
                    end
                end
                TX_STOP: begin
                    if (tick) begin
                        if (s_ff.tx_sub == 4'(`UFC_OVS - 1)) begin
                            nxt_s.tx_sub = 4'h0;
                            nxt_s.tx_st = TX_IDLE;
                            nxt_s.irq_sts[`UFC_IRQ_TX_DONE] = 1'b1;
                        end else begin
                            nxt_s.tx_sub = s_ff.tx_sub + 4'h1;
                        end
                    end
                end
                default: nxt_s.tx_st = TX_IDLE;
            endcase
            if (dis) begin
                // Aborted frame is lost; a pending byte waits for re-enable
                nxt_s.tx_st = TX_IDLE; // [RULE_04]
                nxt_s.tx_line = 1'b1;
                nxt_s.tx_sub = 4'h0;
            end

            // ****************************************
            // Receiver
            // ****************************************
            idle_limit = 8'(`UFC_OVS * (s_ff.ctrl[`UFC_FC_WORD_LEN] ?
                         `UFC_BITS_FRAME9 : `UFC_BITS_FRAME8));
            case (s_ff.rx_st)
                RX_IDLE: begin
                    if (!RXD) begin
                        nxt_s.idle_cnt = 8'h00;
                        if (!dis) begin
                            nxt_s.rx_len9 = s_ff.ctrl[`UFC_FC_WORD_LEN]; // [RULE_05]
                            nxt_s.rx_pce = s_ff.ctrl[`UFC_FC_PCE]; // [RULE_10]
                            nxt_s.rx_ps = s_ff.ctrl[`UFC_FC_PTYPE]; // [RULE_12]
                            nxt_s.rx_sub = 4'h0;
                            nxt_s.rx_st = RX_START;
                        end
                    end else if (tick && s_ff.idle_cnt != idle_limit) begin
                        nxt_s.idle_cnt = s_ff.idle_cnt + 8'h01;
                    end else if (s_ff.idle_cnt == idle_limit && s_ff.mute &&
                                 !s_ff.ctrl[`UFC_FC_WAKE]) begin
                        nxt_s.mute = 1'b0; // [RULE_07]
                    end
                end
                RX_START: begin
                    if (tick) begin
                        if (s_ff.rx_sub == 4'(`UFC_MID - 1)) begin
                            nxt_s.rx_sub = 4'h0;
                            nxt_s.rx_bit = 4'h0;
                            // Glitch shorter than half a bit is not a start
                            nxt_s.rx_st = RXD ? RX_IDLE : RX_DATA;
                        end else begin
                            nxt_s.rx_sub = s_ff.rx_sub + 4'h1;
                        end
                    end
                end
                RX_DATA: begin
                    if (tick) begin
                        if (s_ff.rx_sub == 4'(`UFC_OVS - 1)) begin
                            nxt_s.rx_sub = 4'h0;
                            nxt_s.rx_sh = {RXD, s_ff.rx_sh[8:1]};
                            if (s_ff.rx_bit == last_bit(s_ff.rx_len9)) begin
                                nxt_s.rx_st = RX_STOP;
                            end else begin
                                nxt_s.rx_bit = s_ff.rx_bit + 4'h1;
                            end
                        end else begin
                            nxt_s.rx_sub = s_ff.rx_sub + 4'h1;
                        end
                    end
                end
                RX_STOP: begin
                    if (tick) begin
                        if (s_ff.rx_sub == 4'(`UFC_OVS - 1)) begin
                            nxt_s.rx_sub = 4'h0;
                            nxt_s.idle_cnt = 8'h00;
                            nxt_s.rx_st = RX_IDLE;
                            word = s_ff.rx_len9 ? s_ff.rx_sh : {1'b0, s_ff.rx_sh[8:1]};
                            word_top = s_ff.rx_len9 ? word[8] : word[7];
                            perr = s_ff.rx_pce &&
                                   (calc_par(word, s_ff.rx_len9, s_ff.rx_ps) != word_top); // [RULE_09]
                            accept = !s_ff.mute || (s_ff.ctrl[`UFC_FC_WAKE] && word_top);
                            if (s_ff.mute && accept) begin
                                nxt_s.mute = 1'b0; // [RULE_07]
                            end
                            if (accept) begin
                                nxt_s.rx_data = word[7:0];
                                nxt_s.rx_ready = 1'b1;
                                nxt_s.irq_sts[`UFC_IRQ_RX_DONE] = 1'b1;
                                if (s_ff.rx_len9) begin
                                    nxt_s.ctrl[`UFC_FC_RX_NINTH] = word[8]; // [RULE_02]
                                end
                                if (perr) begin
                                    nxt_s.pe_flag = 1'b1; // [RULE_14]
                                    nxt_s.irq_sts[`UFC_IRQ_PERR] = 1'b1;
                                end
                            end
                        end else begin
                            nxt_s.rx_sub = s_ff.rx_sub + 4'h1;
                        end
                    end
                end
                default: nxt_s.rx_st = RX_IDLE;
            endcase
            if (dis) begin
                nxt_s.rx_st = RX_IDLE; // [RULE_04]
                nxt_s.rx_sub = 4'h0;
            end
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            s_ff <= '0;
            s_ff.tx_st <= TX_IDLE;
            s_ff.rx_st <= RX_IDLE;
            s_ff.tx_line <= 1'b1;
            s_ff.ctrl <= `UFC_RST_FRAME_CTRL; // [RULE_01]
            s_ff.irq_en <= `UFC_RST_IRQ_EN;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign RDATA = s_ff.rdata;
    assign TXD = s_ff.tx_line;
    assign TXD_OE = !dis; // [RULE_04]
    // Parity source is gated by its own enable as well
    assign IRQ = |(s_ff.irq_sts & s_ff.irq_en &
                   {2'b11, s_ff.ctrl[`UFC_FC_PIE]}); // [RULE_13]

endmodule : ufc_frame_ctrl
`default_nettype wire

/* File: verification/ufc_frame_ctrl_properties.sv */
// Port-level checks for the frame format control block
`timescale 1ns/1ps
`default_nettype none
`include "ufc_regs.svh"
module ufc_frame_ctrl_properties
    import ufc_pkg::*;
#(
    parameter int SAMPLE_DIV = 13
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic CE,
    // Register port
    input wire ufc_bus_req_t BUS_REQ,
    input wire logic [7:0] RDATA,
    // Serial line and interrupt
    input wire logic RXD,
    input wire logic TXD,
    input wire logic TXD_OE,
    input wire logic IRQ
);
    localparam int BIT = 16 * SAMPLE_DIV;
    logic wr_fc, rd_fc, rd_st, acc_dat;
    int low_ff;
    logic [2:0] en_ff;
    logic pie_ff;
    assign wr_fc = CE && BUS_REQ.wr && BUS_REQ.addr == `UFC_OFS_FRAME_CTRL;
    assign rd_fc = CE && BUS_REQ.rd && BUS_REQ.addr == `UFC_OFS_FRAME_CTRL;
    assign rd_st = CE && BUS_REQ.rd && BUS_REQ.addr == `UFC_OFS_STATUS;
    assign acc_dat = CE && (BUS_REQ.rd || BUS_REQ.wr) && BUS_REQ.addr == `UFC_OFS_DATA;
    // Low run counted in enabled cycles only, since a frozen prescaler stretches bits
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            low_ff <= 0;
            en_ff <= 3'h0;
            pie_ff <= 1'b0;
        end else if (CE) begin
            low_ff <= TXD ? 0 : low_ff + 1;
            if (BUS_REQ.wr && BUS_REQ.addr == `UFC_OFS_IRQ_EN) begin
                en_ff <= BUS_REQ.wdata[2:0];
            end
            if (wr_fc) begin
                pie_ff <= BUS_REQ.wdata[`UFC_FC_PIE];
            end
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    rst_idle_a: assert property ($rose(RST_B) |-> TXD && TXD_OE && !IRQ && RDATA == 8'h00)
        else $error("Outputs not idle after reset");
    ctrl_read_a: assert property (wr_fc ##1 rd_fc |=> RDATA[6:0] == $past(BUS_REQ.wdata[6:0], 2))
        else $error("Control bits read back wrong");
    disable_oe_a: assert property (wr_fc && BUS_REQ.wdata[`UFC_FC_DISABLE] |=> !TXD_OE)
        else $error("Output still enabled after disable");
    disable_line_a: assert property (!TXD_OE && !$past(TXD_OE) |-> TXD)
        else $error("Line not idle while disabled");
    bit_len_a: assert property ($rose(TXD) && TXD_OE && $past(TXD_OE) |-> low_ff % BIT == 0)
        else $error("Low run not a whole number of bits");
    frame_len_a: assert property (low_ff <= 10 * BIT)
        else $error("Line low longer than start plus nine bits");
    irq_gate_a: assert property ((en_ff & {2'b11, pie_ff}) == 3'h0 |-> !IRQ)
        else $error("Interrupt raised with all sources masked");
    pe_clear_a: assert property (rd_st ##[1:4] acc_dat ##[1:4] rd_st |=> !RDATA[`UFC_ST_PERR])
        else $error("Parity error flag survived clear sequence");
    cover property ($fell(TXD_OE));
    cover property ($rose(IRQ));
    cover property (wr_fc ##1 rd_fc);
endmodule : ufc_frame_ctrl_properties
`default_nettype wire

/* File: verification/ufc_serial_partner.sv */
// Behavioural remote serial partner: frame sender and frame catcher
`timescale 1ns/1ps
`default_nettype none
module ufc_serial_partner #(
    parameter int BIT = 16
) (
    // Clock
    input wire logic clk,
    // Line from the block, line to the block
    input wire logic line_in,
    output logic line_out
);
    logic [8:0] got;
    int got_cnt;
    initial begin
        line_out = 1'b1;
        got = 9'h000;
        got_cnt = 0;
    end
    // Start, data LSB first, one stop
    task automatic send(input logic [8:0] w, input int n);
        line_out <= 1'b0;
        repeat (BIT) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            line_out <= w[i];
            repeat (BIT) @(posedge clk);
        end
        line_out <= 1'b1;
        repeat (BIT) @(posedge clk);
    endtask : send
    // Nine mid-bit slots; in eight-bit frames the last one is the stop bit
    always begin
        @(negedge line_in);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT) @(posedge clk);
            got[i] = line_in;
        end
        got_cnt++;
    end
endmodule : ufc_serial_partner
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the frame format control block
`timescale 1ns/1ps
`default_nettype none
`include "ufc_regs.svh"
module tb;
    import ufc_pkg::*;
    localparam int DIV = 1;
    localparam int BIT = 16 * DIV;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] dat;
        logic [8:0] exp;
        logic [8:0] flip;
    } ufc_row_t;
    // Control, byte sent, nine slots seen on the line, bits corrupted on the way back
    ufc_row_t rows [10] = '{
        '{8'h00, 8'hA5, 9'h1A5, 9'h000}, '{8'h10, 8'h3C, 9'h03C, 9'h000},
        '{8'h50, 8'h00, 9'h100, 9'h000}, '{8'h04, 8'h07, 9'h187, 9'h000},
        '{8'h06, 8'h87, 9'h107, 9'h000}, '{8'h14, 8'h01, 9'h101, 9'h000},
        '{8'h16, 8'h03, 9'h103, 9'h000}, '{8'h05, 8'h00, 9'h100, 9'h001},
        '{8'h14, 8'h00, 9'h000, 9'h002}, '{8'h07, 8'h00, 9'h180, 9'h080}};
    logic clk_sys, rst_b, ce, rxd, txd, txd_oe, irq, n9, pe;
    ufc_bus_req_t req;
    logic [7:0] rdata, v;
    logic [8:0] w, x;
    ufc_row_t r;
    int num_errors, comparisons, c;
    ufc_frame_ctrl #(.SAMPLE_DIV(DIV)) uut (
        .CLK_SYS(clk_sys), .RST_B(rst_b), .CE(ce), .BUS_REQ(req), .RDATA(rdata),
        .RXD(rxd), .TXD(txd), .TXD_OE(txd_oe), .IRQ(irq));
    ufc_serial_partner #(.BIT(BIT)) p (.clk(clk_sys), .line_in(txd), .line_out(rxd));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // ****
    // Bus and check tasks
    // ****
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t ns: got 0x%h exp 0x%h", $time, got, exp);
        end
    endtask : chk
    // Strobe stays up so back-to-back requests need no gap
    task automatic acc(input logic w_en, input logic [3:0] a, input logic [7:0] d);
        req <= '{addr: a, wdata: d, wr: w_en, rd: !w_en};
        @(posedge clk_sys);
    endtask : acc
    task automatic idle(output logic [7:0] d);
        req.wr <= 1'b0;
        req.rd <= 1'b0;
        #1;
        d = rdata;
        @(posedge clk_sys);
    endtask : idle
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        acc(1'b0, a, 8'h00);
        idle(d);
    endtask : rd
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] t;
        acc(1'b1, a, d);
        idle(t);
    endtask : wr
    task automatic wait_tx(output logic [8:0] q);
        int c0;
        c0 = p.got_cnt;
        for (int i = 0; i < 400 && p.got_cnt == c0; i++) begin
            @(posedge clk_sys);
        end
        q = p.got;
        if (p.got_cnt == c0) begin
            chk(9'h000, 9'h001);
            stop_test();
        end
    endtask : wait_tx
    // ****
    // Main sequence
    // ****
    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        req = '0;
        num_errors = 0;
        comparisons = 0;
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        rd(`UFC_OFS_FRAME_CTRL, v);
        chk(9'(v[6:0]), 9'h000);
        wr(4'hF, 8'hFF);
        rd(4'hF, v);
        chk(9'(v), 9'h000);
        wr(`UFC_OFS_IRQ_EN, 8'h01);
        for (int i = 0; i < 10; i++) begin
            r = rows[i];
            n9 = r.ctrl[`UFC_FC_WORD_LEN];
            acc(1'b1, `UFC_OFS_FRAME_CTRL, r.ctrl);
            acc(1'b0, `UFC_OFS_FRAME_CTRL, 8'h00);
            idle(v);
            chk(9'(v[6:0]), 9'(r.ctrl[6:0]));
            wr(`UFC_OFS_DATA, r.dat);
            wait_tx(w);
            chk(w, r.exp);
            x = r.exp ^ r.flip;
            pe = r.ctrl[2] && ((n9 ? ^x : ^x[7:0]) != r.ctrl[1]);
            p.send(x, n9 ? 9 : 8);
            for (int k = 0; k < 20; k++) begin
                rd(`UFC_OFS_STATUS, v);
                if (v[`UFC_ST_RX_READY]) break;
            end
            chk(9'(v[1:0]), 9'({1'b1, pe}));
            chk(9'(irq), 9'(pe && r.ctrl[0]));
            rd(`UFC_OFS_DATA, v);
            chk(9'(v), 9'(x[7:0]));
            rd(`UFC_OFS_STATUS, v);
            chk(9'(v[0]), 9'h000);
            if (n9) begin
                rd(`UFC_OFS_FRAME_CTRL, v);
                chk(9'(v[7]), 9'(x[8]));
            end
            wr(`UFC_OFS_IRQ_CLR, 8'h07);
            chk(9'(irq), 9'h000);
        end
        // Parity settings written mid-frame must wait for the next frame
        wr(`UFC_OFS_FRAME_CTRL, 8'h00);
        wr(`UFC_OFS_DATA, 8'h00);
        repeat (2 * BIT) @(posedge clk_sys);
        wr(`UFC_OFS_FRAME_CTRL, 8'h06);
        wait_tx(w);
        chk(w, 9'h100);
        wr(`UFC_OFS_DATA, 8'h00);
        wait_tx(w);
        chk(w, 9'h180);
        // Disable in mid-frame: line released, frame not resumed
        wr(`UFC_OFS_DATA, 8'h00);
        repeat (3 * BIT) @(posedge clk_sys);
        wr(`UFC_OFS_FRAME_CTRL, 8'h26);
        @(posedge clk_sys);
        chk(9'({txd_oe, txd}), 9'h001);
        repeat (12 * BIT) @(posedge clk_sys);
        c = p.got_cnt;
        wr(`UFC_OFS_FRAME_CTRL, 8'h06);
        repeat (12 * BIT) @(posedge clk_sys);
        chk(9'(p.got_cnt - c), 9'h000);
        // Muted receiver wakes only on an address mark
        wr(`UFC_OFS_FRAME_CTRL, 8'h18);
        wr(`UFC_OFS_MUTE, 8'h01);
        p.send(9'h055, 9);
        rd(`UFC_OFS_STATUS, v);
        chk(9'(v[1]), 9'h000);
        p.send(9'h1AA, 9);
        rd(`UFC_OFS_MUTE, v);
        chk(9'(v[0]), 9'h000);
        rd(`UFC_OFS_DATA, v);
        chk(9'(v), 9'h0AA);
        // Idle-line wake: a marked word is still dropped, a quiet frame time unmutes
        wr(`UFC_OFS_FRAME_CTRL, 8'h10);
        wr(`UFC_OFS_MUTE, 8'h01);
        p.send(9'h133, 9);
        rd(`UFC_OFS_STATUS, v);
        chk(9'(v[1]), 9'h000);
        repeat (12 * BIT) @(posedge clk_sys);
        rd(`UFC_OFS_MUTE, v);
        chk(9'(v[0]), 9'h000);
        // Clock enable low: a write in that cycle is dropped
        ce <= 1'b0;
        wr(`UFC_OFS_FRAME_CTRL, 8'h20);
        ce <= 1'b1;
        chk(9'(txd_oe), 9'h001);
        rd(`UFC_OFS_FRAME_CTRL, v);
        chk(9'(v[6:0]), 9'h010);
        // Reset in mid-run returns the control bits to zero
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        rd(`UFC_OFS_FRAME_CTRL, v);
        chk(9'(v[6:0]), 9'h000);
        stop_test();
    end
endmodule : tb
bind ufc_frame_ctrl ufc_frame_ctrl_properties #(.SAMPLE_DIV(SAMPLE_DIV)) u_props (
    .CLK_SYS(CLK_SYS), .RST_B(RST_B), .CE(CE), .BUS_REQ(BUS_REQ), .RDATA(RDATA),
    .RXD(RXD), .TXD(TXD), .TXD_OE(TXD_OE), .IRQ(IRQ));
`default_nettype wire
